// file: rtl/posc_pkg.sv
/*
 * shared constants of the pwm output stage controller: register map,
 * field positions, reset values, mode codes and timing.
 * assumes a 100 MHz system clock and an axi4-lite master on the bus side.
 */
package posc_pkg;
	// pwm resolution and the mid-supply bias duty
	localparam int DUTY_W = 8;
	localparam logic [7:0] DUTY_HALF = 8'h80;
	localparam logic [7:0] DUTY_ZERO = 8'h00;
	localparam logic [7:0] DUTY_TOP = 8'hFF;

	// register map, byte addresses
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_POWER = 4'h0;
	localparam logic [3:0] OFF_OUTCFG = 4'h4;
	localparam logic [3:0] OFF_VOLUME = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'hC;

	// field positions
	localparam int PWR_GPD_BIT = 0;
	localparam int PWR_PPD_LSB = 1;
	localparam int CFG_SEL_LSB = 0;
	localparam int CFG_MAP_LSB = 2;
	localparam int CFG_SPD_LSB = 4;
	localparam int CFG_DRV_BIT = 6;
	localparam int CFG_XOV_BIT = 7;

	// output configuration codes
	localparam logic [1:0] CFG_STEREO_FB = 2'h0;
	localparam logic [1:0] CFG_HB_SUB = 2'h1;
	localparam logic [1:0] CFG_PARALLEL = 2'h2;
	localparam logic [1:0] CFG_RSVD = 2'h3;

	// logic-level output mapping codes
	localparam logic [1:0] MAP_OFF = 2'h0;
	localparam logic [1:0] MAP_CH1_CH2 = 2'h1;
	localparam logic [1:0] MAP_CH1_SUB = 2'h2;
	localparam logic [1:0] MAP_CH2_SUB = 2'h3;

	// ramp speed code that means instant transitions
	localparam logic [1:0] SPD_OFF = 2'h3;
	localparam logic [7:0] VOL_MUTE = 8'hFF;

	// reset values
	localparam logic RST_GPD = 1'b1;
	localparam logic [3:0] RST_PPD = 4'h0;
	localparam logic [1:0] RST_CFG = CFG_STEREO_FB;
	localparam logic [1:0] RST_MAP = MAP_OFF;
	localparam logic [1:0] RST_SPD = SPD_OFF;
	localparam logic RST_DRV = 1'b0;
	localparam logic RST_XOV = 1'b0;
	localparam logic [7:0] RST_VOL = 8'h00;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
	localparam int RAMP_STEPS = 128;
	localparam int RAMP_TIME_MS_00 = 2160;
	localparam int RAMP_TIME_MS_01 = 2200;
	localparam int RAMP_TIME_MS_10 = 2200;
	localparam logic [2:0] STARTUP_PERIODS = 3'h4;
endpackage

// file: rtl/posc_modulator.sv
/*
 * one pwm modulator: compares the shared period count with a duty value
 * latched at the start of each period.
 * assumes count wraps through 0 once per pwm period on the same clock.
 */
`timescale 1ns/1ps
module posc_modulator import posc_pkg::*; #(
	parameter int W = DUTY_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [W-1:0] count,
	input wire logic [W-1:0] duty,
	output logic pwm
);
	typedef struct packed {
		logic [W-1:0] duty_l;
		logic pwm;
	} posc_mod_type;

	posc_mod_type r;
	posc_mod_type next_r;
	logic [W-1:0] cur_duty;

	// duty only changes at a period boundary, so no runt pulses appear
	always_comb begin
		next_r = r;
		cur_duty = (count == '0) ? duty : r.duty_l;
		if (count == '0) begin
			next_r.duty_l = duty;
		end
		next_r.pwm = run && (count < cur_duty);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign pwm = r.pwm;
endmodule

// file: rtl/posc_ramp.sv
/*
 * linear ramp of one powered output between zero and the bias duty.
 * assumes step is a one-cycle pulse from the shared ramp timer.
 */
`timescale 1ns/1ps
module posc_ramp import posc_pkg::*; #(
	parameter int W = DUTY_W,
	parameter logic [W-1:0] BIAS = DUTY_HALF
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic target_on,
	input wire logic instant,
	input wire logic step,
	output logic [W-1:0] level,
	output logic at_bias,
	output logic at_zero
);
	typedef struct packed {
		logic [W-1:0] level;
		logic at_bias;
		logic at_zero;
	} posc_ramp_type;

	posc_ramp_type r;
	posc_ramp_type next_r;

	// one step per timer pulse; instant mode jumps straight to the end
	always_comb begin
		next_r = r;
		if (instant) begin
			next_r.level = target_on ? BIAS : '0;
		end else if (step && target_on && r.level < BIAS) begin
			next_r.level = r.level + 1'b1;
		end else if (step && !target_on && r.level != '0) begin
			next_r.level = r.level - 1'b1;
		end
		next_r.at_bias = (next_r.level == BIAS);
		next_r.at_zero = (next_r.level == '0);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '{level: '0, at_bias: 1'b0, at_zero: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	assign level = r.level;
	assign at_bias = r.at_bias;
	assign at_zero = r.at_zero;
endmodule

// file: rtl/posc_top.sv
/*
 * pwm output stage controller: axi4-lite registers, routing of channels
 * onto four powered pins and two logic-level pins, pop-suppression ramps,
 * mute and power-down handling.
 * assumes audio duty words arrive on clk; in_a is an asynchronous pin.
 */

`timescale 1ns/1ps
module posc_top import posc_pkg::*; #(
	parameter int RAMP_STEP_CYC_00 = RAMP_TIME_MS_00 * CYC_PER_MS / RAMP_STEPS,
	parameter int RAMP_STEP_CYC_01 = RAMP_TIME_MS_01 * CYC_PER_MS / RAMP_STEPS,
	parameter int RAMP_STEP_CYC_10 = RAMP_TIME_MS_10 * CYC_PER_MS / RAMP_STEPS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [DUTY_W-1:0] ch_a_duty,
	input wire logic [DUTY_W-1:0] ch_b_duty,
	input wire logic [DUTY_W-1:0] sub_duty,
	input wire logic [DUTY_W-1:0] xover_hp_duty,
	input wire logic [DUTY_W-1:0] xover_lp_duty,
	input wire logic in_a,
	output logic power_out_a,
	output logic power_out_b,
	output logic power_out_c,
	output logic power_out_d,
	output logic logic_pwm_power_out_a,
	output logic logic_pwm_power_out_a_oe,
	output logic logic_pwm_power_out_b,
	output logic logic_pwm_power_out_b_oe
);
	typedef struct packed {
		logic aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic global_powerdown;
		logic [3:0] per_output_powerdown;
		logic [1:0] output_config_sel;
		logic [1:0] logic_pwm_map_sel;
		logic [1:0] ramp_speed;
		logic logic_pwm_driver_en;
		logic xover_en;
		logic [7:0] volume;
		logic [DUTY_W-1:0] count;
		logic [31:0] tick_cnt;
		logic mute_s1;
		logic mute_s2;
		logic [2:0] start_cnt;
		logic lout1;
		logic lout2;
		logic loe1;
		logic loe2;
	} posc_state_type;

	posc_state_type r;
	posc_state_type next_r;

	logic [DUTY_W-1:0] ch1;
	logic [DUTY_W-1:0] ch2;
	logic [DUTY_W-1:0] aud [4];
	logic [DUTY_W-1:0] pin_duty [4];
	logic [DUTY_W-1:0] level [4];
	logic [3:0] at_bias;
	logic [3:0] at_zero;
	logic [3:0] pin_pwm;
	logic [DUTY_W-1:0] ldutyA;
	logic [DUTY_W-1:0] ldutyB;
	logic lpwm1;
	logic lpwm2;
	logic mute;
	logic step;
	logic instant;
	logic lrun;
	logic [31:0] step_cyc;
	logic [31:0] status;

	// channel sources follow the processing path in use
	assign ch1 = r.xover_en ? xover_hp_duty : ch_a_duty;
	assign ch2 = r.xover_en ? xover_lp_duty : ch_b_duty;
	assign mute = (r.volume == VOL_MUTE) || r.mute_s2;
	assign instant = (r.ramp_speed == SPD_OFF);

	// one speed code picks the step interval shared by all four ramps
	always_comb begin
		unique case (r.ramp_speed)
			2'h0: step_cyc = 32'(RAMP_STEP_CYC_00);
			2'h1: step_cyc = 32'(RAMP_STEP_CYC_01);
			2'h2: step_cyc = 32'(RAMP_STEP_CYC_10);
			2'h3: step_cyc = 32'h1;
		endcase
	end
	assign step = (r.tick_cnt >= step_cyc - 32'h1);

	// pin mapping of the powered outputs; mute idles them at bias
	always_comb begin
		logic [DUTY_W-1:0] c1;
		logic [DUTY_W-1:0] c2;
		logic [DUTY_W-1:0] sb;
		c1 = mute ? DUTY_HALF : ch1;
		c2 = mute ? DUTY_HALF : ch2;
		sb = mute ? DUTY_HALF : sub_duty;
		unique case (r.output_config_sel)
			CFG_HB_SUB: begin
				aud[0] = c1;
				aud[1] = c2;
				aud[2] = sb;
				aud[3] = ~sb;
			end
			CFG_PARALLEL: begin
				aud[0] = c1;
				aud[1] = c1;
				aud[2] = ~c1;
				aud[3] = ~c1;
			end
			default: begin
				aud[0] = c1;
				aud[1] = ~c1;
				aud[2] = c2;
				aud[3] = ~c2;
			end
		endcase
	end

	// each powered pin ramps on its own power bits, at the shared speed
	for (genvar i = 0; i < 4; i++) begin : g_pin
		posc_ramp #(.W(DUTY_W), .BIAS(DUTY_HALF)) u_ramp (
			.clk(clk),
			.reset(reset),
			.target_on(!r.global_powerdown && !r.per_output_powerdown[i]),
			.instant(instant),
			.step(step),
			.level(level[i]),
			.at_bias(at_bias[i]),
			.at_zero(at_zero[i])
		);
		// audio passes only once the pin sits at bias
		assign pin_duty[i] = at_bias[i] ? aud[i] : level[i];
		// a pin that ramped to zero has its modulator stopped
		posc_modulator #(.W(DUTY_W)) u_mod (
			.clk(clk),
			.reset(reset),
			.run(!at_zero[i]),
			.count(r.count),
			.duty(pin_duty[i]),
			.pwm(pin_pwm[i])
		);
	end

	assign power_out_a = pin_pwm[0];
	assign power_out_b = pin_pwm[1];
	assign power_out_c = pin_pwm[2];
	assign power_out_d = pin_pwm[3];

	// logic-level sources; no ramp here, only mute and start-up idle
	always_comb begin
		unique case (r.logic_pwm_map_sel)
			MAP_CH1_CH2: begin
				ldutyA = ch1;
				ldutyB = ch2;
			end
			MAP_CH1_SUB: begin
				ldutyA = ch1;
				ldutyB = sub_duty;
			end
			MAP_CH2_SUB: begin
				ldutyA = ch2;
				ldutyB = sub_duty;
			end
			MAP_OFF: begin
				ldutyA = DUTY_ZERO;
				ldutyB = DUTY_ZERO;
			end
		endcase
		if (mute || r.start_cnt != 3'h0) begin
			ldutyA = DUTY_HALF;
			ldutyB = DUTY_HALF;
		end
	end
	assign lrun = !r.global_powerdown && (r.logic_pwm_map_sel != MAP_OFF);

	// logic-level modulators ignore the ramp entirely
	posc_modulator #(.W(DUTY_W)) u_lmod1 (
		.clk(clk),
		.reset(reset),
		.run(lrun),
		.count(r.count),
		.duty(ldutyA),
		.pwm(lpwm1)
	);
	posc_modulator #(.W(DUTY_W)) u_lmod2 (
		.clk(clk),
		.reset(reset),
		.run(lrun),
		.count(r.count),
		.duty(ldutyB),
		.pwm(lpwm2)
	);

	assign status = {22'h0, lrun, mute, at_zero, at_bias};

	// bus slave, control registers, timers and the pin synchroniser
	always_comb begin
		next_r = r;
		next_r.mute_s1 = in_a;
		next_r.mute_s2 = r.mute_s1;
		next_r.count = r.count + 1'b1;
		next_r.tick_cnt = step ? 32'h0 : r.tick_cnt + 32'h1;
		// idle periods after leaving power-down, counted at wraps
		if (r.global_powerdown) begin
			next_r.start_cnt = STARTUP_PERIODS;
		end else if (r.count == DUTY_TOP && r.start_cnt != 3'h0) begin
			next_r.start_cnt = r.start_cnt - 3'h1;
		end
		// write address and data are taken independently
		if (r.awready && s_axi_awvalid) begin
			next_r.aw_have = 1'b1;
			next_r.aw_addr = s_axi_awaddr;
		end
		if (r.wready && s_axi_wvalid) begin
			next_r.w_have = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end
		if (r.aw_have && r.w_have && !r.bvalid) begin
			next_r.aw_have = 1'b0;
			next_r.w_have = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = RESP_OKAY;
			unique case (r.aw_addr)
				OFF_POWER: begin
					if (r.wstrb[0]) begin
						next_r.global_powerdown = r.wdata[PWR_GPD_BIT];
						next_r.per_output_powerdown = r.wdata[PWR_PPD_LSB +: 4];
					end
				end
				OFF_OUTCFG: begin
					if (r.wstrb[0]) begin
						// lock while running; reserved code never lands
						if (r.global_powerdown &&
								r.wdata[CFG_SEL_LSB +: 2] != CFG_RSVD) begin
							next_r.output_config_sel = r.wdata[CFG_SEL_LSB +: 2];
						end
						next_r.logic_pwm_map_sel = r.wdata[CFG_MAP_LSB +: 2];
						next_r.ramp_speed = r.wdata[CFG_SPD_LSB +: 2];
						next_r.logic_pwm_driver_en = r.wdata[CFG_DRV_BIT];
						next_r.xover_en = r.wdata[CFG_XOV_BIT];
					end
				end
				OFF_VOLUME: begin
					if (r.wstrb[0]) begin
						next_r.volume = r.wdata[7:0];
					end
				end
				OFF_STATUS: begin
				end
				default: begin
					next_r.bresp = RESP_SLVERR;
				end
			endcase
		end
		next_r.awready = !next_r.aw_have;
		next_r.wready = !next_r.w_have;
		// read path: one outstanding read, data registered
		if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
		if (r.arready && s_axi_arvalid) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				OFF_POWER: next_r.rdata = {27'h0, r.per_output_powerdown,
					r.global_powerdown};
				OFF_OUTCFG: next_r.rdata = {24'h0, r.xover_en,
					r.logic_pwm_driver_en, r.ramp_speed,
					r.logic_pwm_map_sel, r.output_config_sel};
				OFF_VOLUME: next_r.rdata = {24'h0, r.volume};
				OFF_STATUS: next_r.rdata = status;
				default: begin
					next_r.rdata = 32'h0;
					next_r.rresp = RESP_SLVERR;
				end
			endcase
		end
		next_r.arready = !next_r.rvalid;
		// drivers float until enabled; power-down forces a low level
		next_r.loe1 = r.logic_pwm_driver_en;
		next_r.loe2 = r.logic_pwm_driver_en;
		next_r.lout1 = lrun && lpwm1;
		next_r.lout2 = lrun && lpwm2;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
			r.global_powerdown <= RST_GPD;
			r.per_output_powerdown <= RST_PPD;
			r.output_config_sel <= RST_CFG;
			r.logic_pwm_map_sel <= RST_MAP;
			r.ramp_speed <= RST_SPD;
			r.logic_pwm_driver_en <= RST_DRV;
			r.xover_en <= RST_XOV;
			r.volume <= RST_VOL;
			r.start_cnt <= STARTUP_PERIODS;
		end else begin
			r <= next_r;
		end
	end

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign logic_pwm_power_out_a = r.lout1;
	assign logic_pwm_power_out_b = r.lout2;
	assign logic_pwm_power_out_a_oe = r.loe1;
	assign logic_pwm_power_out_b_oe = r.loe2;

	// checks
	a_cfg_locked: assert property (@(posedge clk) disable iff (reset)
		!r.global_powerdown |=> $stable(r.output_config_sel))
		else $error("output config changed while running");
	a_cfg_legal: assert property (@(posedge clk) disable iff (reset)
		r.output_config_sel != CFG_RSVD)
		else $error("reserved output config accepted");
	a_ramp_instant: assert property (@(posedge clk) disable iff (reset)
		instant |=> (level[0] == DUTY_ZERO || level[0] == DUTY_HALF) &&
			(level[3] == DUTY_ZERO || level[3] == DUTY_HALF))
		else $error("ramp not instant with speed code 11");
	a_ramp_linear: assert property (@(posedge clk) disable iff (reset)
		!instant && !step |=> $stable(level[1]))
		else $error("ramp moved without a step");
	a_logic_hiz: assert property (@(posedge clk) disable iff (reset)
		!r.logic_pwm_driver_en |=> !logic_pwm_power_out_a_oe && !logic_pwm_power_out_b_oe)
		else $error("logic driver enabled while disabled");
	a_pd_low: assert property (@(posedge clk) disable iff (reset)
		r.global_powerdown |=> ##1 !logic_pwm_power_out_a && !logic_pwm_power_out_b)
		else $error("logic output high in power-down");
	a_mod_stop: assert property (@(posedge clk) disable iff (reset)
		r.global_powerdown && (&at_zero) |=> !power_out_a && !power_out_b
			&& !power_out_c && !power_out_d)
		else $error("powered modulator running in power-down");
	a_mute_half: assert property (@(posedge clk) disable iff (reset)
		mute && r.logic_pwm_map_sel != MAP_OFF |->
			ldutyA == DUTY_HALF && ldutyB == DUTY_HALF)
		else $error("mute did not give half duty");
	a_route_sub: assert property (@(posedge clk) disable iff (reset)
		r.output_config_sel == CFG_HB_SUB && at_bias[2] && !mute |->
			pin_duty[2] == sub_duty && pin_duty[3] == ~sub_duty)
		else $error("sub not on pins c and d");
	a_xover_src: assert property (@(posedge clk) disable iff (reset)
		r.xover_en |-> ch1 == xover_hp_duty && ch2 == xover_lp_duty)
		else $error("crossover outputs not routed");
endmodule

// file: verification/posc_amp_model.sv
/*
 * partner model: external pwm amplifier fed by logic-level output 1.
 * assumes the bench resolves the pin level, z while nobody drives it.
 */
`timescale 1ns/1ps
module posc_amp_model (
	input wire logic clk,
	input wire logic amp_run,
	input wire logic pin1,
	output logic dc_fault
);
	logic last;
	int still;
	// a released amplifier whose input never toggles puts dc on the speaker
	initial begin
		dc_fault = 1'b0;
		last = 1'b0;
		still = 0;
	end
	always @(posedge clk) begin
		if (!amp_run || pin1 !== last) begin
			still <= 0;
		end else begin
			still <= still + 1;
		end
		last <= pin1;
		if (amp_run && still > 600) begin
			dc_fault <= 1'b1;
		end
	end
endmodule

// file: verification/tb_pwm_output_stage_ctrl.sv
/*
 * self-checking bench of the output stage controller: axi4-lite master,
 * duty counting on all pins against an integer model, amplifier partner.
 * assumes ramp steps shortened to 4 cycles per step.
 */
`timescale 1ns/1ps
module tb_pwm_output_stage_ctrl import posc_pkg::*;;
	logic clk, reset, in_a, amp_run, dc_fault;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [7:0] ch_a_duty, ch_b_duty, sub_duty, xover_hp_duty, xover_lp_duty;
	logic power_out_a, power_out_b, power_out_c, power_out_d;
	logic logic_pwm_power_out_a, logic_pwm_power_out_a_oe, logic_pwm_power_out_b, logic_pwm_power_out_b_oe;
	wire sig1 = logic_pwm_power_out_a_oe ? logic_pwm_power_out_a : 1'bz;
	wire sig2 = logic_pwm_power_out_b_oe ? logic_pwm_power_out_b : 1'bz;
	wire [5:0] pins = {sig2, sig1, power_out_d, power_out_c, power_out_b,
		power_out_a};
	int num_errors, checks, c1, c2, sb, hp, lp;
	int cnt [6];

	posc_top #(.RAMP_STEP_CYC_00(4), .RAMP_STEP_CYC_01(4),
		.RAMP_STEP_CYC_10(4)) u_dut (.clk, .reset, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch_a_duty,
		.ch_b_duty, .sub_duty, .xover_hp_duty, .xover_lp_duty, .in_a,
		.power_out_a, .power_out_b, .power_out_c, .power_out_d,
		.logic_pwm_power_out_a, .logic_pwm_power_out_a_oe, .logic_pwm_power_out_b,
		.logic_pwm_power_out_b_oe);
	posc_amp_model u_amp (.clk, .amp_run, .pin1(sig1), .dc_fault);

	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#1000000;
		num_errors++;
		complete_run();
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// one write: address and data offered together, bready held to the answer
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 1000);
		if (n >= 1000) num_errors++;
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rdr(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 1000);
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (n >= 1000) num_errors++;
	endtask

	// counting over 256 cycles gives the duty, whatever the window phase
	task automatic measure(input int w);
		repeat (w) @(posedge clk);
		cnt = '{default:0};
		repeat (256) begin
			@(posedge clk);
			for (int i = 0; i < 6; i++) cnt[i] += (pins[i] === 1'b1);
		end
	endtask
	function automatic int pdut(int cfg, int p);
		int q[$];
		case (cfg)
			0: q = '{c1, 255 - c1, c2, 255 - c2};
			1: q = '{c1, c2, sb, 255 - sb};
			default: q = '{c1, c1, 255 - c1, 255 - c1};
		endcase
		return q[p];
	endfunction
	task automatic check_all(input int cfg, input int map);
		int q[$];
		q = '{0, 0, c1, c2, c1, sb, c2, sb};
		for (int i = 0; i < 4; i++) check("power", cnt[i], pdut(cfg, i));
		check("sig1", cnt[4], q[map * 2]);
		check("sig2", cnt[5], q[map * 2 + 1]);
	endtask

	// main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, in_a, amp_run} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{ch_a_duty, ch_b_duty, sub_duty, xover_hp_duty, xover_lp_duty} = '0;
		num_errors = 0;
		checks = 0;
		rd = $urandom(32'h2EC4);
		reset = 1'b1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		rdr(OFF_POWER, rd, rs);
		check("power reg", rd, 32'h01);
		rdr(OFF_OUTCFG, rd, rs);
		check("outcfg reg", rd, 32'h30);
		rdr(4'h2, rd, rs);
		check("unmapped", {rs, rd[29:0]}, {RESP_SLVERR, 30'h0});
		check("oe", logic_pwm_power_out_a_oe, 1'b0);
		wr(OFF_OUTCFG, 32'h31);
		wr(OFF_OUTCFG, 32'h33);
		rdr(OFF_OUTCFG, rd, rs);
		check("reserved cfg", rd, 32'h31);
		wr(OFF_POWER, 32'h0);
		wr(OFF_OUTCFG, 32'h30);
		rdr(OFF_OUTCFG, rd, rs);
		check("locked cfg", rd, 32'h31);
		for (int k = 0; k < 6; k++) begin
			wr(OFF_POWER, 32'h1);
			{c1, c2, sb} = {$urandom_range(239, 16), $urandom_range(239, 16),
				$urandom_range(239, 16)};
			{hp, lp} = {$urandom_range(239, 16), $urandom_range(239, 16)};
			ch_a_duty <= c1[7:0];
			ch_b_duty <= c2[7:0];
			sub_duty <= sb[7:0];
			xover_hp_duty <= hp[7:0];
			xover_lp_duty <= lp[7:0];
			if (k % 2 == 1) {c1, c2} = {hp, lp};
			wr(OFF_OUTCFG, (k % 2) << 7 | 32'h70 | (k % 4) << 2 | k / 2);
			wr(OFF_POWER, 32'h0);
			measure(300);
			check("startup", cnt[4], k % 4 ? 128 : 0);
			measure(1000);
			check_all(k / 2, k % 4);
		end
		wr(OFF_VOLUME, 32'hFF);
		{c1, c2, sb} = {128, 128, 128};
		measure(800);
		check_all(2, 1);
		wr(OFF_VOLUME, 32'h0);
		in_a <= 1'b1;
		measure(800);
		check_all(2, 1);
		in_a <= 1'b0;
		wr(OFF_POWER, 32'h1);
		measure(10);
		{c1, c2, sb} = {0, 255, 0};
		check("sig1 off", cnt[4], 0);
		check("oe on", logic_pwm_power_out_a_oe, 1'b1);
		check("pin a off", cnt[0], 0);
		// ramps with speed 00, pin a held down by its own bit
		wr(OFF_OUTCFG, 32'h05);
		// the enable follows the register one edge later
		@(posedge clk);
		check("oe off", logic_pwm_power_out_b_oe, 1'b0);
		wr(OFF_POWER, 32'h2);
		repeat (50) @(posedge clk);
		rdr(OFF_STATUS, rd, rs);
		check("ramping up", rd[7:0], 8'h10);
		repeat (700) @(posedge clk);
		rdr(OFF_STATUS, rd, rs);
		check("at bias", rd[7:0], 8'h1E);
		wr(OFF_POWER, 32'h1);
		repeat (50) @(posedge clk);
		rdr(OFF_STATUS, rd, rs);
		check("ramping down", rd[7:0], 8'h10);
		repeat (700) @(posedge clk);
		rdr(OFF_STATUS, rd, rs);
		check("at zero", rd[7:0], 8'hF0);
		// host order for an external amplifier, then its power-down order
		wr(OFF_OUTCFG, 32'h75);
		wr(OFF_POWER, 32'h0);
		repeat (20) @(posedge clk);
		amp_run <= 1'b1;
		measure(1400);
		check("sig1 audio", cnt[4], ch_a_duty);
		wr(OFF_VOLUME, 32'hFF);
		measure(600);
		check("sig1 mute", cnt[4], 128);
		amp_run <= 1'b0;
		wr(OFF_POWER, 32'h1);
		check("no dc", dc_fault, 1'b0);
		// headphone start: drivers stay floating until after lock
		wr(OFF_OUTCFG, 32'h35);
		wr(OFF_POWER, 32'h0);
		repeat (100) @(posedge clk);
		check("hp float", logic_pwm_power_out_a_oe, 1'b0);
		wr(OFF_OUTCFG, 32'h75);
		@(posedge clk);
		check("hp drive", logic_pwm_power_out_a_oe, 1'b1);
		complete_run();
	end
endmodule
